/* erb_array.sv */
`timescale 1ns/100ps
module erb_array (
   // clock, reset only gates the checks
   input wire logic clk_i,
   input wire logic rst_n_i,
   // write ports; port a wins a lane both write
   input wire erb_pkg::erb_wr_s wr_a_i,
   input wire erb_pkg::erb_wr_s wr_b_i,
   // read ports, combinational from the flops
   input wire logic [6:0] rd_a_idx_i,
   input wire logic [6:0] rd_b_idx_i,
   output logic [35:0] rd_a_o,
   output logic [35:0] rd_b_o
);

   erb_pkg::erb_mem_s st_r;
   erb_pkg::erb_mem_s st_nxt; // next contents
   logic [6:0] wa_idx; // helper for checks
   logic [35:0] wa_data; // helper for checks
   logic [8:0] keep_old; // lane 0 before the write

   // lane-wise update, untouched lanes keep their value
   always_comb begin
      st_nxt = st_r;
      for (int l = 0; l < erb_pkg::LANES; l++) begin
         if (wr_b_i.mask[l]) begin
            st_nxt.word[wr_b_i.idx][l*erb_pkg::LANE_W +: erb_pkg::LANE_W] =
               wr_b_i.data[l*erb_pkg::LANE_W +: erb_pkg::LANE_W];
         end
         if (wr_a_i.mask[l]) begin
            st_nxt.word[wr_a_i.idx][l*erb_pkg::LANE_W +: erb_pkg::LANE_W] =
               wr_a_i.data[l*erb_pkg::LANE_W +: erb_pkg::LANE_W];
         end
      end
   end

   // contents are not reset so a preload survives a reset
   always_ff @(posedge clk_i) begin
      st_r <= st_nxt;
   end

   // reads see the old word; bypass is the caller's job
   assign rd_a_o = st_r.word[rd_a_idx_i];
   assign rd_b_o = st_r.word[rd_b_idx_i];

   assign wa_idx = wr_a_i.idx;
   assign wa_data = wr_a_i.data;
   assign keep_old = st_r.word[wr_a_i.idx][8:0];

   a_size_total: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $bits(st_r.word) == erb_pkg::TOTAL_BITS)
      else $error("array size is not the block capacity");

   a_lane_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (!wr_a_i.mask[0] && !wr_b_i.mask[0])
      |=> st_r.word[$past(wa_idx)][8:0] === $past(keep_old))
      else $error("unmasked lane changed");

   a_word_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (wr_a_i.mask == 4'hf) |=> st_r.word[$past(wa_idx)] == $past(wa_data))
      else $error("full word write lost");

endmodule : erb_array

/* erb_fabric_model.sv */
`timescale 1ns/100ps
// fabric user logic: pulses requests and records read answers
module erb_fabric_model (
   // clock
   input wire logic clk_i,
   // answers from the block
   input wire logic [35:0] a_q_i,
   input wire logic a_qvalid_i,
   input wire logic [35:0] b_q_i,
   input wire logic b_qvalid_i,
   // requests to the block
   output erb_pkg::erb_req_s a_req_o,
   output erb_pkg::erb_req_s b_req_o
);
   int lat; // cycles to first qvalid, 0 when none came
   logic [35:0] qa; // last word read on port a
   logic [35:0] qb; // last word read on port b
   initial begin
      a_req_o = '0;
      b_req_o = '0;
   end
   // one request cycle, then idle while watching for qvalid
   task automatic drive(input erb_pkg::erb_req_s a,
                        input erb_pkg::erb_req_s b);
      @(posedge clk_i);
      a_req_o <= a;
      b_req_o <= b;
      lat = 0;
      for (int i = 1; i < 8; i++) begin
         @(posedge clk_i);
         // idle data inverted so stale values cannot pass
         a_req_o <= '{a.addr, ~a.wdata, 4'h0, 1'b0, 1'b0, 1'b0};
         b_req_o <= '{b.addr, ~b.wdata, 4'h0, 1'b0, 1'b0, 1'b0};
         #1;
         if (a_qvalid_i === 1'b1) qa = a_q_i;
         if (b_qvalid_i === 1'b1) qb = b_q_i;
         if (lat == 0 && (a_qvalid_i === 1'b1 || b_qvalid_i === 1'b1))
            lat = i;
      end
   endtask : drive
endmodule : erb_fabric_model

/* erb_pkg.sv */
package erb_pkg;

   // storage organisation: 128 words of four 9-bit lanes
   localparam int WORDS = 128;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int WORD_W = 36;
   localparam int TOTAL_BITS = 4608;

   // register byte offsets on the apb side
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SHIFT = 8'h04;
   localparam logic [7:0] OFS_INIT_ADDR = 8'h08;
   localparam logic [7:0] OFS_INIT_DATA = 8'h0c;
   localparam logic [7:0] OFS_INIT_PAR = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;

   // control register field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_WIDTH_LSB = 3;
   localparam int CTRL_OREG_BIT = 5;
   localparam int CTRL_PACK_BIT = 6;
   localparam int CTRL_RUN_BIT = 7;

   // values after reset, and the fifo level that counts as full
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [6:0] SHIFT_LAST_RST = 7'h7f;
   localparam logic [7:0] FIFO_FULL_CNT = 8'h80;

   // memory modes
   typedef enum logic [2:0] {
      ERB_TDP = 3'b000,
      ERB_SDP = 3'b001,
      ERB_SP = 3'b010,
      ERB_ROM = 3'b011,
      ERB_FIFO = 3'b100,
      ERB_SHIFT = 3'b101
   } erb_mode_e;

   // port widths; x9 is one byte plus its parity bit
   typedef enum logic [1:0] {
      ERB_W9 = 2'b00,
      ERB_W18 = 2'b01,
      ERB_W36 = 2'b10
   } erb_width_e;

   // one fabric port request
   typedef struct packed {
      logic [8:0] addr;
      logic [35:0] wdata;
      logic [3:0] be;
      logic we;
      logic re;
      logic hold;
   } erb_req_s;

   // apb request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } erb_apb_req_s;

   // one write port of the array
   typedef struct packed {
      logic [6:0] idx;
      logic [3:0] mask;
      logic [35:0] data;
   } erb_wr_s;

   // array contents
   typedef struct packed {
      logic [WORDS-1:0][WORD_W-1:0] word;
   } erb_mem_s;

   // all control and datapath state of the top
   typedef struct packed {
      erb_req_s in_a;
      erb_req_s in_b;
      logic [7:0] ctrl;
      logic [6:0] shift_last;
      logic [6:0] init_idx;
      logic [3:0] init_par;
      logic [6:0] wr_ptr;
      logic [6:0] rd_ptr;
      logic [7:0] cnt;
      logic [6:0] sh_ptr;
      logic full;
      logic empty;
      logic [35:0] pipe_a;
      logic [35:0] pipe_b;
      logic pv_a;
      logic pv_b;
      logic [35:0] q_a;
      logic [35:0] q_b;
      logic qv_a;
      logic qv_b;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } erb_state_s;

endpackage : erb_pkg

/* erb_ram_block.sv */
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
// Notes on behaviour
// - inputs always registered; output stage selectable
// - storage holds 4608 bits including parity
// - modes: dual, simple dual, single, rom, fifo, shift
// - each byte carries its own parity bit
// - byte masking for all supported port widths
// - packing needs half size each, one clock
// - address hold keeps the previous address
// - contents preloadable before operation starts
// - same-port read during write returns new data
// - mixed-port read during write returns old data
module erb_ram_block (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // apb slave
   input wire erb_pkg::erb_apb_req_s apb_i,
   output logic pready_o,
   output logic pslverr_o,
   output logic [31:0] prdata_o,
   // fabric port a
   input wire erb_pkg::erb_req_s a_req_i,
   output logic [35:0] a_q_o,
   output logic a_qvalid_o,
   // fabric port b
   input wire erb_pkg::erb_req_s b_req_i,
   output logic [35:0] b_q_o,
   output logic b_qvalid_o,
   // output clear and fifo flags
   input wire logic clr_i,
   output logic fifo_full_o,
   output logic fifo_empty_o
);

   erb_pkg::erb_state_s st_r; // registered state
   erb_pkg::erb_state_s nxt; // next state
   erb_pkg::erb_mode_e mode; // decoded mode
   erb_pkg::erb_width_e width; // decoded port width
   logic oreg; // output register in use
   logic pack; // two half memories share the block
   logic run; // user ports live
   erb_pkg::erb_wr_s wr_a; // array write port a
   erb_pkg::erb_wr_s wr_b; // array write port b
   logic [6:0] rd_a_idx; // array read index a
   logic [6:0] rd_b_idx; // array read index b
   logic [35:0] rd_a_word; // raw old word a
   logic [35:0] rd_b_word; // raw old word b
   logic [6:0] a_idx; // port a word index
   logic [6:0] b_idx; // port b word index
   logic [3:0] a_mask; // port a lane mask
   logic [3:0] b_mask; // port b lane mask
   logic [35:0] a_fmt; // formatted read data a
   logic [35:0] b_fmt; // formatted read data b
   logic a_rd; // port a read this cycle
   logic b_rd; // port b read this cycle
   logic push; // fifo write accepted
   logic pop; // fifo read accepted
   logic shift; // shift register step
   logic acc; // apb access phase
   logic commit; // apb write takes effect now

   // word index from a port address at the given width
   function automatic logic [6:0] word_idx(erb_pkg::erb_width_e w,
                                          logic [8:0] a);
      case (w)
         erb_pkg::ERB_W36: word_idx = a[6:0];
         erb_pkg::ERB_W18: word_idx = a[7:1];
         default: word_idx = a[8:2];
      endcase
   endfunction : word_idx

   // lanes written for a given width, sub address and byte enables
   function automatic logic [3:0] lane_mask(erb_pkg::erb_width_e w,
                                           logic [8:0] a, logic [3:0] be);
      case (w)
         erb_pkg::ERB_W36: lane_mask = be;
         erb_pkg::ERB_W18: lane_mask = a[0] ? {be[1:0], 2'b00}
                                            : {2'b00, be[1:0]};
         default: lane_mask = {4{be[0]}} & (4'h1 << a[1:0]);
      endcase
   endfunction : lane_mask

   // narrow write data copied onto every lane it may land in
   function automatic logic [35:0] align_w(erb_pkg::erb_width_e w,
                                          logic [35:0] d);
      case (w)
         erb_pkg::ERB_W36: align_w = d;
         erb_pkg::ERB_W18: align_w = {2{d[17:0]}};
         default: align_w = {4{d[8:0]}};
      endcase
   endfunction : align_w

   // pick the addressed lanes out of a word, low aligned
   function automatic logic [35:0] align_r(erb_pkg::erb_width_e w,
                                          logic [8:0] a, logic [35:0] d);
      case (w)
         erb_pkg::ERB_W36: align_r = d;
         erb_pkg::ERB_W18: align_r = {18'h0, a[0] ? d[35:18] : d[17:0]};
         default: begin
            case (a[1:0])
               2'b00: align_r = {27'h0, d[8:0]};
               2'b01: align_r = {27'h0, d[17:9]};
               2'b10: align_r = {27'h0, d[26:18]};
               default: align_r = {27'h0, d[35:27]};
            endcase
         end
      endcase
   endfunction : align_r

   // old word with the written lanes replaced
   function automatic logic [35:0] merge(logic [35:0] old, logic [35:0] nw,
                                        logic [3:0] m);
      merge = old;
      for (int l = 0; l < erb_pkg::LANES; l++) begin
         if (m[l]) begin
            merge[l*erb_pkg::LANE_W +: erb_pkg::LANE_W] =
               nw[l*erb_pkg::LANE_W +: erb_pkg::LANE_W];
         end
      end
   endfunction : merge

   // preload word: byte i in lane i, parity bit on top of it
   function automatic logic [35:0] init_word(logic [3:0] par,
                                            logic [31:0] d);
      init_word = '0;
      for (int l = 0; l < erb_pkg::LANES; l++) begin
         init_word[l*erb_pkg::LANE_W +: erb_pkg::LANE_W] =
            {par[l], d[l*8 +: 8]};
      end
   endfunction : init_word

   // storage array
   erb_array u_array (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .wr_a_i(wr_a),
      .wr_b_i(wr_b),
      .rd_a_idx_i(rd_a_idx),
      .rd_b_idx_i(rd_b_idx),
      .rd_a_o(rd_a_word),
      .rd_b_o(rd_b_word)
   );

   // whole next-state computation
   always_comb begin
      nxt = st_r;
      mode = erb_pkg::erb_mode_e'(st_r.ctrl[erb_pkg::CTRL_MODE_LSB +: 3]);
      width = erb_pkg::erb_width_e'(st_r.ctrl[erb_pkg::CTRL_WIDTH_LSB +: 2]);
      oreg = st_r.ctrl[erb_pkg::CTRL_OREG_BIT];
      pack = st_r.ctrl[erb_pkg::CTRL_PACK_BIT];
      run = st_r.ctrl[erb_pkg::CTRL_RUN_BIT];
      // input registers load on every edge, no bypass
      nxt.in_a = a_req_i;
      nxt.in_b = b_req_i;
      if (a_req_i.hold) begin
         nxt.in_a.addr = st_r.in_a.addr;
      end
      if (b_req_i.hold) begin
         nxt.in_b.addr = st_r.in_b.addr;
      end
      // decode the registered requests
      a_idx = word_idx(width, st_r.in_a.addr);
      b_idx = word_idx(width, st_r.in_b.addr);
      if (mode == erb_pkg::ERB_SP && pack) begin
         a_idx[6] = 1'b0;
         b_idx[6] = 1'b1;
      end
      a_mask = lane_mask(width, st_r.in_a.addr, st_r.in_a.be);
      b_mask = lane_mask(width, st_r.in_b.addr, st_r.in_b.be);
      wr_a = '0;
      wr_b = '0;
      rd_a_idx = a_idx;
      rd_b_idx = b_idx;
      a_rd = 1'b0;
      b_rd = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      shift = 1'b0;
      // mode decides which port may read or write
      if (run) begin
         case (mode)
            erb_pkg::ERB_TDP, erb_pkg::ERB_SP: begin
               wr_a.idx = a_idx;
               wr_a.mask = st_r.in_a.we ? a_mask : 4'h0;
               wr_a.data = align_w(width, st_r.in_a.wdata);
               a_rd = st_r.in_a.re;
               // single-port uses b only when packed
               if (mode == erb_pkg::ERB_TDP || pack) begin
                  wr_b.idx = b_idx;
                  wr_b.mask = st_r.in_b.we ? b_mask : 4'h0;
                  wr_b.data = align_w(width, st_r.in_b.wdata);
                  b_rd = st_r.in_b.re;
               end
            end
            erb_pkg::ERB_SDP: begin
               wr_a.idx = a_idx;
               wr_a.mask = st_r.in_a.we ? a_mask : 4'h0;
               wr_a.data = align_w(width, st_r.in_a.wdata);
               b_rd = st_r.in_b.re;
            end
            erb_pkg::ERB_ROM: begin
               a_rd = st_r.in_a.re;
               b_rd = st_r.in_b.re;
            end
            erb_pkg::ERB_FIFO: begin
               // read from empty is dropped, even with a write
               push = st_r.in_a.we & ~st_r.full;
               pop = st_r.in_b.re & ~st_r.empty;
               wr_a.idx = st_r.wr_ptr;
               wr_a.mask = push ? 4'hf : 4'h0;
               wr_a.data = st_r.in_a.wdata;
               rd_b_idx = st_r.rd_ptr;
               b_rd = pop;
            end
            erb_pkg::ERB_SHIFT: begin
               // old word leaves on b as the new one goes in
               shift = st_r.in_a.we;
               wr_a.idx = st_r.sh_ptr;
               wr_a.mask = shift ? 4'hf : 4'h0;
               wr_a.data = st_r.in_a.wdata;
               rd_b_idx = st_r.sh_ptr;
               b_rd = shift;
            end
            default: begin
            end
         endcase
      end
      // same port sees its own write, other port the old word
      a_fmt = merge(rd_a_word, wr_a.data,
                    (wr_a.idx == rd_a_idx) ? wr_a.mask : 4'h0);
      b_fmt = merge(rd_b_word, wr_b.data,
                    (wr_b.idx == rd_b_idx) ? wr_b.mask : 4'h0);
      if (mode != erb_pkg::ERB_FIFO && mode != erb_pkg::ERB_SHIFT) begin
         a_fmt = align_r(width, st_r.in_a.addr, a_fmt);
         b_fmt = align_r(width, st_r.in_b.addr, b_fmt);
      end
      // fifo pointers and level
      if (push) begin
         nxt.wr_ptr = st_r.wr_ptr + 7'h01;
      end
      if (pop) begin
         nxt.rd_ptr = st_r.rd_ptr + 7'h01;
      end
      case ({push, pop})
         2'b10: nxt.cnt = st_r.cnt + 8'h01;
         2'b01: nxt.cnt = st_r.cnt - 8'h01;
         default: nxt.cnt = st_r.cnt;
      endcase
      // shift tap pointer wraps at the programmed last tap
      if (shift) begin
         nxt.sh_ptr = (st_r.sh_ptr == st_r.shift_last) ? 7'h00
                                                       : st_r.sh_ptr + 7'h01;
      end
      // output stage: one extra flop when registered
      if (oreg) begin
         if (a_rd) begin
            nxt.pipe_a = a_fmt;
         end
         if (b_rd) begin
            nxt.pipe_b = b_fmt;
         end
         nxt.pv_a = a_rd;
         nxt.pv_b = b_rd;
         if (st_r.pv_a) begin
            nxt.q_a = st_r.pipe_a;
         end
         if (st_r.pv_b) begin
            nxt.q_b = st_r.pipe_b;
         end
         nxt.qv_a = st_r.pv_a;
         nxt.qv_b = st_r.pv_b;
      end else begin
         // bypass: the same flop takes the array word directly
         if (a_rd) begin
            nxt.q_a = a_fmt;
         end
         if (b_rd) begin
            nxt.q_b = b_fmt;
         end
         nxt.qv_a = a_rd;
         nxt.qv_b = b_rd;
         nxt.pv_a = 1'b0;
         nxt.pv_b = 1'b0;
      end
      // clear reaches the output side only
      if (clr_i) begin
         nxt.pipe_a = '0;
         nxt.pipe_b = '0;
         nxt.q_a = '0;
         nxt.q_b = '0;
         nxt.pv_a = 1'b0;
         nxt.pv_b = 1'b0;
         nxt.qv_a = 1'b0;
         nxt.qv_b = 1'b0;
      end
      // apb: one wait state, answer decided before pready rises
      acc = apb_i.psel & apb_i.penable;
      nxt.pready = acc & ~st_r.pready;
      nxt.pslverr = 1'b0;
      nxt.prdata = '0;
      if (acc && !st_r.pready) begin
         case (apb_i.paddr)
            erb_pkg::OFS_CTRL: nxt.prdata = {24'h0, st_r.ctrl};
            erb_pkg::OFS_SHIFT: nxt.prdata = {25'h0, st_r.shift_last};
            erb_pkg::OFS_INIT_ADDR: nxt.prdata = {25'h0, st_r.init_idx};
            erb_pkg::OFS_INIT_PAR: nxt.prdata = {28'h0, st_r.init_par};
            // preload only while the user ports are stopped
            erb_pkg::OFS_INIT_DATA: nxt.pslverr = apb_i.pwrite & run;
            erb_pkg::OFS_STATUS: begin
               nxt.prdata = {22'h0, st_r.cnt, st_r.full, st_r.empty};
               nxt.pslverr = apb_i.pwrite;
            end
            default: nxt.pslverr = 1'b1;
         endcase
      end
      commit = acc & st_r.pready & apb_i.pwrite & ~st_r.pslverr;
      if (commit) begin
         case (apb_i.paddr)
            erb_pkg::OFS_CTRL: begin
               // a new setup restarts fifo and shift pointers
               nxt.ctrl = apb_i.pwdata[7:0];
               nxt.wr_ptr = 7'h00;
               nxt.rd_ptr = 7'h00;
               nxt.cnt = 8'h00;
               nxt.sh_ptr = 7'h00;
            end
            erb_pkg::OFS_SHIFT: begin
               nxt.shift_last = apb_i.pwdata[6:0];
               nxt.sh_ptr = 7'h00;
            end
            erb_pkg::OFS_INIT_ADDR: nxt.init_idx = apb_i.pwdata[6:0];
            erb_pkg::OFS_INIT_PAR: nxt.init_par = apb_i.pwdata[3:0];
            erb_pkg::OFS_INIT_DATA: begin
               wr_a.idx = st_r.init_idx;
               wr_a.mask = 4'hf;
               wr_a.data = init_word(st_r.init_par, apb_i.pwdata);
               nxt.init_idx = st_r.init_idx + 7'h01;
            end
            default: begin
            end
         endcase
      end
      nxt.full = (nxt.cnt == erb_pkg::FIFO_FULL_CNT);
      nxt.empty = (nxt.cnt == 8'h00);
      // power-up: outputs cleared except fifo empty, which is set, block stopped
      if (!rst_n_i) begin
         nxt = '0;
         nxt.ctrl = erb_pkg::CTRL_RST;
         nxt.shift_last = erb_pkg::SHIFT_LAST_RST;
         nxt.empty = 1'b1;
      end
   end

   // single state register
   always_ff @(posedge clk_i) begin
      st_r <= nxt;
   end

   // outputs straight from flops
   assign pready_o = st_r.pready;
   assign pslverr_o = st_r.pslverr;
   assign prdata_o = st_r.prdata;
   assign a_q_o = st_r.q_a;
   assign a_qvalid_o = st_r.qv_a;
   assign b_q_o = st_r.q_b;
   assign b_qvalid_o = st_r.qv_b;
   assign fifo_full_o = st_r.full;
   assign fifo_empty_o = st_r.empty;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_rd_piped;
      (a_rd && oreg && !clr_i) ##1 (oreg && !clr_i);
   endsequence

   sequence s_tdp_wide;
      run && mode == erb_pkg::ERB_TDP && width == erb_pkg::ERB_W36 && !oreg;
   endsequence

   a_out_bypass: assert property ((a_rd && !oreg && !clr_i)
      |=> a_qvalid_o && a_q_o == $past(a_fmt))
      else $error("bypassed read not presented next cycle");

   a_out_piped: assert property (s_rd_piped
      |=> a_qvalid_o && a_q_o == $past(a_fmt, 2))
      else $error("registered read not presented two cycles on");

   a_rom_nowrite: assert property ((run && mode == erb_pkg::ERB_ROM)
      |-> wr_a.mask == 4'h0 && wr_b.mask == 4'h0)
      else $error("rom mode wrote the array");

   a_fifo_level: assert property ((push && !pop && !commit)
      |=> st_r.cnt == $past(st_r.cnt) + 8'h01 && !fifo_empty_o
      && fifo_full_o == (st_r.cnt == erb_pkg::FIFO_FULL_CNT))
      else $error("fifo flags wrong after push");

   a_lane_single: assert property ((width == erb_pkg::ERB_W9)
      |-> $onehot0(a_mask) && $onehot0(b_mask))
      else $error("byte lane mask not single");

   a_pack_split: assert property ((run && mode == erb_pkg::ERB_SP && pack)
      |-> !rd_a_idx[6] && rd_b_idx[6])
      else $error("packed halves overlap");

   a_hold_addr: assert property ((a_req_i.hold || b_req_i.hold)
      |=> (!$past(a_req_i.hold) || st_r.in_a.addr == $past(st_r.in_a.addr))
      && (!$past(b_req_i.hold) || st_r.in_b.addr == $past(st_r.in_b.addr)))
      else $error("address moved while held");

   a_init_load: assert property ((commit && apb_i.paddr ==
      erb_pkg::OFS_INIT_DATA) |-> wr_a.mask == 4'hf ##1
      st_r.init_idx == $past(st_r.init_idx) + 7'h01)
      else $error("preload write not taken");

   a_same_new: assert property ((s_tdp_wide and (a_rd && !clr_i &&
      wr_a.mask == 4'hf && wr_a.idx == rd_a_idx)) |=> a_q_o == $past(wr_a.data))
      else $error("same port did not read new data");

   a_mixed_old: assert property ((s_tdp_wide and (b_rd && !clr_i &&
      wr_b.mask == 4'h0 && wr_a.idx == rd_b_idx)) |=> b_q_o == $past(rd_b_word))
      else $error("other port did not read old data");

   a_clear_out: assert property (clr_i
      |=> a_q_o == '0 && b_q_o == '0 && !a_qvalid_o && !b_qvalid_o)
      else $error("output not cleared");

   a_apb_pulse: assert property ((acc && !pready_o) |=> pready_o ##1 !pready_o)
      else $error("apb answer not a single cycle");

endmodule : erb_ram_block

/* erb_ram_block_tb.sv */
`timescale 1ns/100ps
module erb_ram_block_tb;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic clr_i = 1'b0;
   erb_pkg::erb_apb_req_s apb_r = '0; // apb master drive
   erb_pkg::erb_req_s a_req, b_req; // fabric requests
   logic pready_o, pslverr_o, a_qv, b_qv, full, empty;
   logic [31:0] prdata_o;
   logic [35:0] a_q, b_q;
   int bad_count = 0;
   int compares = 0;
   int cyc = 0; // timeout counter
   logic [31:0] rdat; // read data taken at pready
   localparam erb_pkg::erb_req_s NOP = '0;
   localparam logic [35:0] W5 = {9'h044, 9'h133, 9'h022, 9'h111};
   localparam logic [35:0] W5M = {9'h044, 9'h1ff, 9'h022, 9'h1ff};
   initial forever #50 clk_i = ~clk_i;
   erb_ram_block i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .apb_i(apb_r),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o),
      .a_req_i(a_req), .a_q_o(a_q), .a_qvalid_o(a_qv), .b_req_i(b_req),
      .b_q_o(b_q), .b_qvalid_o(b_qv), .clr_i(clr_i), .fifo_full_o(full),
      .fifo_empty_o(empty));
   erb_fabric_model i_fab (.clk_i(clk_i), .a_q_i(a_q), .a_qvalid_i(a_qv),
      .b_q_i(b_q), .b_qvalid_i(b_qv), .a_req_o(a_req), .b_req_o(b_req));
   task automatic chk(input string nm, input logic [35:0] e,
                      input logic [35:0] g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   // one apb transfer; held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] ad,
                      input logic [31:0] wd, input logic ee);
      @(posedge clk_i);
      apb_r <= '{1'b1, 1'b0, w, ad, wd};
      @(posedge clk_i);
      apb_r.penable <= 1'b1;
      // this wait ends when pready is sampled high
      do begin
         @(posedge clk_i);
      end while (pready_o !== 1'b1);
      rdat = prdata_o;
      chk("pslverr", {35'h0, ee}, {35'h0, pslverr_o});
      apb_r <= '0;
   endtask : apb
   task automatic ctl(input logic [31:0] v);
      apb(1'b1, erb_pkg::OFS_CTRL, v, 1'b0);
   endtask : ctl
   // request: wrh is {we, re, hold}
   function automatic erb_pkg::erb_req_s rq(input logic [8:0] ad,
      input logic [35:0] d, input logic [3:0] be, input logic [2:0] wrh);
      return '{ad, d, be, wrh[2], wrh[1], wrh[0]};
   endfunction : rq
   task automatic print_verdict();
      if (bad_count == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict
   // hang guard, about twice the cycles the tests need
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         bad_count++;
         print_verdict();
      end
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      #1;
      chk("empty", 36'h1, {35'h0, empty});
      chk("a_q", 36'h0, a_q);
      apb(1'b1, erb_pkg::OFS_INIT_ADDR, 32'h5, 1'b0);
      apb(1'b1, erb_pkg::OFS_INIT_PAR, 32'h5, 1'b0);
      apb(1'b1, erb_pkg::OFS_INIT_DATA, 32'h44332211, 1'b0);
      ctl(32'h90);
      apb(1'b0, erb_pkg::OFS_CTRL, 32'h0, 1'b0);
      chk("prdata", 36'h90, {4'h0, rdat});
      apb(1'b1, erb_pkg::OFS_INIT_DATA, 32'h0, 1'b1);
      apb(1'b0, 8'h40, 32'h0, 1'b1);
      i_fab.drive(rq(9'h5, 36'h0, 4'h0, 3'b010), NOP);
      chk("a_q", W5, i_fab.qa);
      chk("lat", 36'h2, 36'(i_fab.lat));
      i_fab.drive(rq(9'h5, {36{1'b1}}, 4'h5, 3'b100), NOP);
      i_fab.drive(rq(9'h5, 36'h0, 4'h0, 3'b010), NOP);
      chk("a_q", W5M, i_fab.qa);
      i_fab.drive(rq(9'h6, 36'h0abcdef12, 4'hf, 3'b110), NOP);
      chk("a_q", 36'h0abcdef12, i_fab.qa);
      i_fab.drive(rq(9'h7, 36'h111111111, 4'hf, 3'b100), NOP);
      i_fab.drive(rq(9'h7, 36'h222222222, 4'hf, 3'b100),
                  rq(9'h7, 36'h0, 4'h0, 3'b010));
      chk("b_q", 36'h111111111, i_fab.qb);
      i_fab.drive(NOP, rq(9'h5, 36'h0, 4'h0, 3'b010));
      i_fab.drive(NOP, rq(9'h6, 36'h0, 4'h0, 3'b011));
      chk("b_q", W5M, i_fab.qb);
      ctl(32'hb0);
      i_fab.drive(rq(9'h7, 36'h0, 4'h0, 3'b010), NOP);
      chk("lat", 36'h3, 36'(i_fab.lat));
      chk("a_q", 36'h222222222, i_fab.qa);
      @(posedge clk_i);
      clr_i <= 1'b1;
      @(posedge clk_i);
      clr_i <= 1'b0;
      #1;
      chk("a_q", 36'h0, a_q);
      ctl(32'h93);
      i_fab.drive(rq(9'h6, 36'h0, 4'hf, 3'b110), NOP);
      chk("a_q", 36'h0abcdef12, i_fab.qa);
      ctl(32'h94);
      i_fab.drive(rq(9'h0, 36'h987654321, 4'h0, 3'b100), NOP);
      chk("empty", 36'h0, {35'h0, empty});
      apb(1'b0, erb_pkg::OFS_STATUS, 32'h0, 1'b0);
      chk("prdata", 36'h4, {4'h0, rdat});
      i_fab.drive(NOP, rq(9'h0, 36'h0, 4'h0, 3'b010));
      chk("b_q", 36'h987654321, i_fab.qb);
      i_fab.drive(NOP, rq(9'h0, 36'h0, 4'h0, 3'b010));
      chk("lat", 36'h0, 36'(i_fab.lat));
      repeat (127) i_fab.drive(rq(9'h0, 36'h0, 4'h0, 3'b100), NOP);
      chk("full", 36'h0, {35'h0, full});
      i_fab.drive(rq(9'h0, 36'h0, 4'h0, 3'b100), NOP);
      chk("full", 36'h1, {35'h0, full});
      ctl(32'hd2);
      i_fab.drive(rq(9'h3, 36'h333333333, 4'hf, 3'b100),
                  rq(9'h3, 36'h444444444, 4'hf, 3'b100));
      i_fab.drive(rq(9'h3, 36'h0, 4'h0, 3'b010),
                  rq(9'h3, 36'h0, 4'h0, 3'b010));
      chk("a_q", 36'h333333333, i_fab.qa);
      chk("b_q", 36'h444444444, i_fab.qb);
      ctl(32'h80);
      i_fab.drive(rq(9'h1, 36'h1a5, 4'h1, 3'b100), NOP);
      i_fab.drive(rq(9'h1, 36'h0, 4'h0, 3'b010), NOP);
      chk("a_q", 36'h1a5, i_fab.qa);
      ctl(32'h91);
      i_fab.drive(rq(9'h8, 36'h5a5a5a5a5, 4'hf, 3'b110), NOP);
      chk("lat", 36'h0, 36'(i_fab.lat));
      i_fab.drive(NOP, rq(9'h8, 36'h0, 4'h0, 3'b010));
      chk("b_q", 36'h5a5a5a5a5, i_fab.qb);
      ctl(32'h95);
      apb(1'b1, erb_pkg::OFS_SHIFT, 32'h1, 1'b0);
      i_fab.drive(rq(9'h0, 36'h5, 4'h0, 3'b100), NOP);
      i_fab.drive(rq(9'h0, 36'h6, 4'h0, 3'b100), NOP);
      i_fab.drive(rq(9'h0, 36'h7, 4'h0, 3'b100), NOP);
      chk("b_q", 36'h5, i_fab.qb);
      print_verdict();
   end
endmodule : erb_ram_block_tb
